// ### hdl/video_clip_shift_scale_dac_force.sv
// The APB register port was chosen for this implementation.
`include "video_csm_defs.svh"

module video_clip_shift_scale_dac_force
   import video_csm_pkg::*;
#(
   parameter int ADDR_W = 12
)
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // video samples from the pixel datapath
   input wire logic pix_valid,
   input wire logic [9:0] gy_in,
   input wire logic [9:0] bcb_in,
   input wire logic [9:0] rcr_in,
   // dac inputs
   output logic dac_valid,
   output logic [9:0] gy_dac,
   output logic [9:0] bcb_dac,
   output logic [9:0] rcr_dac
);

   // address must reach bit 10, the upper-bit decode reads paddr above bit 9
   if (ADDR_W < 11)
   begin : g_addr_w_check
      $error("ADDR_W too small for the register map");
   end

   localparam int NCH = 3;
   localparam logic [7:0] BASE_IDX = `IDX_DAC_FORCE_AND_UPPER_BITS;

   // register storage, entry 0 is index 0x3D
   reg_byte_t regs_ff [0:`REG_COUNT-1];
   // apb answer flops
   logic pready_ff;
   logic pslverr_ff;
   logic [31:0] prdata_ff;

   // decoded index and hit
   logic [7:0] acc_idx;
   logic acc_hit;
   logic [4:0] acc_slot;

   // reset value per slot
   function automatic reg_byte_t reset_value(input logic [7:0] idx);
      reg_byte_t v;
      v = `RST_ZERO;
      if (idx == `IDX_GY_LOW_CLIP_LEVEL || idx == `IDX_BCB_LOW_CLIP_LEVEL
          || idx == `IDX_RCR_LOW_CLIP_LEVEL)
      begin
         v = `RST_LOW_CLIP;
      end
      else if (idx == `IDX_GY_HIGH_CLIP_OFFSET)
      begin
         v = `RST_GY_HIGH_CLIP;
      end
      else if (idx == `IDX_BCB_HIGH_CLIP_OFFSET || idx == `IDX_RCR_HIGH_CLIP_OFFSET)
      begin
         v = `RST_CHROMA_HIGH_CLIP;
      end
      else if (idx == `IDX_GY_SHIFT_AMOUNT || idx == `IDX_BCB_SHIFT_AMOUNT
               || idx == `IDX_RCR_SHIFT_AMOUNT)
      begin
         v = `RST_SHIFT;
      end
      else if (idx == `IDX_GY_CONTROL_AND_GAIN_UPPER)
      begin
         // overflow guard is on out of reset
         v = `RST_GY_CONTROL;
      end
      return v;
   endfunction : reset_value

   // writable bits per slot; reserved bits stay zero
   function automatic reg_byte_t write_mask(input logic [7:0] idx);
      reg_byte_t m;
      m = 8'hFF;
      if (idx == `IDX_DAC_FORCE_AND_UPPER_BITS)
      begin
         m = `MASK_DAC_FORCE;
      end
      else if (idx == `IDX_CHROMA_GAIN_UPPER_BITS)
      begin
         m = `MASK_CHROMA_GAIN_UPPER;
      end
      return m;
   endfunction : write_mask

   // address decode: word aligned, index inside the map
   always_comb
   begin
      acc_idx = paddr[9:2];
      acc_slot = 5'h00;
      acc_hit = 1'b0;
      if (paddr[1:0] != 2'h0)
      begin
         acc_hit = 1'b0;
      end
      else if (|paddr[ADDR_W-1:10])
      begin
         acc_hit = 1'b0;
      end
      else if (acc_idx >= `IDX_DAC_FORCE_AND_UPPER_BITS && acc_idx <= `IDX_CHROMA_CONTROL)
      begin
         acc_hit = 1'b1;
         acc_slot = 5'(acc_idx - BASE_IDX);
      end
   end

   // apb answer: decided in setup, presented through the access phase
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h0000_0000;
      end
      else if (psel && !penable)
      begin
         // one wait-free access phase; error for unmapped addresses
         pready_ff <= 1'b1;
         pslverr_ff <= !acc_hit;
         prdata_ff <= acc_hit ? {24'h00_0000, regs_ff[acc_slot]} : 32'h0000_0000;
      end
      else
      begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h0000_0000;
      end
   end

   // register writes take effect on the completing access edge
   generate
      for (genvar r = 0; r < `REG_COUNT; r++)
      begin : g_reg
         localparam logic [7:0] IDX = 8'(int'(BASE_IDX) + r);
         always_ff @(posedge ref_clk)
         begin
            if (!rstn)
            begin
               regs_ff[r] <= reset_value(IDX);
            end
            else if (psel && penable && pready_ff && pwrite && acc_hit
                     && acc_slot == 5'(r))
            begin
               regs_ff[r] <= pwdata[7:0] & write_mask(IDX);
            end
         end
      end
   endgenerate

   // per-channel configuration pulled out of the map
   sample_t cfg_forced [NCH];
   reg_byte_t cfg_low [NCH];
   reg_byte_t cfg_high [NCH];
   reg_byte_t cfg_shift [NCH];
   gain_t cfg_gain [NCH];
   logic cfg_gain_en [NCH];
   logic cfg_shift_en [NCH];
   logic cfg_high_en [NCH];
   logic cfg_low_en [NCH];
   logic overflow_guard_enable;
   logic dac_force;

   // slot helpers
   function automatic int slot(input logic [7:0] idx);
      return int'(idx) - int'(BASE_IDX);
   endfunction : slot

   // field extraction
   always_comb
   begin
      overflow_guard_enable = regs_ff[slot(`IDX_GY_CONTROL_AND_GAIN_UPPER)][`BIT_OVERFLOW_GUARD];
      dac_force = regs_ff[slot(`IDX_DAC_FORCE_AND_UPPER_BITS)][`BIT_DAC_FORCE];
      cfg_forced[CH_GY] = {regs_ff[slot(`IDX_DAC_FORCE_AND_UPPER_BITS)][5:4],
                           regs_ff[slot(`IDX_GY_DAC_FORCED_LOW)]};
      cfg_forced[CH_BCB] = {regs_ff[slot(`IDX_DAC_FORCE_AND_UPPER_BITS)][3:2],
                            regs_ff[slot(`IDX_BCB_DAC_FORCED_LOW)]};
      cfg_forced[CH_RCR] = {regs_ff[slot(`IDX_DAC_FORCE_AND_UPPER_BITS)][1:0],
                            regs_ff[slot(`IDX_RCR_DAC_FORCED_LOW)]};
      cfg_low[CH_GY] = regs_ff[slot(`IDX_GY_LOW_CLIP_LEVEL)];
      cfg_low[CH_BCB] = regs_ff[slot(`IDX_BCB_LOW_CLIP_LEVEL)];
      cfg_low[CH_RCR] = regs_ff[slot(`IDX_RCR_LOW_CLIP_LEVEL)];
      cfg_high[CH_GY] = regs_ff[slot(`IDX_GY_HIGH_CLIP_OFFSET)];
      cfg_high[CH_BCB] = regs_ff[slot(`IDX_BCB_HIGH_CLIP_OFFSET)];
      cfg_high[CH_RCR] = regs_ff[slot(`IDX_RCR_HIGH_CLIP_OFFSET)];
      cfg_shift[CH_GY] = regs_ff[slot(`IDX_GY_SHIFT_AMOUNT)];
      cfg_shift[CH_BCB] = regs_ff[slot(`IDX_BCB_SHIFT_AMOUNT)];
      cfg_shift[CH_RCR] = regs_ff[slot(`IDX_RCR_SHIFT_AMOUNT)];
      cfg_gain[CH_GY] = {regs_ff[slot(`IDX_GY_CONTROL_AND_GAIN_UPPER)][2:0],
                         regs_ff[slot(`IDX_GY_GAIN_LOW)]};
      cfg_gain[CH_BCB] = {regs_ff[slot(`IDX_CHROMA_GAIN_UPPER_BITS)][6:4],
                          regs_ff[slot(`IDX_BCB_GAIN_LOW)]};
      cfg_gain[CH_RCR] = {regs_ff[slot(`IDX_CHROMA_GAIN_UPPER_BITS)][2:0],
                          regs_ff[slot(`IDX_RCR_GAIN_LOW)]};
      cfg_gain_en[CH_GY] = regs_ff[slot(`IDX_GY_CONTROL_AND_GAIN_UPPER)][`BIT_GY_GAIN_EN];
      cfg_shift_en[CH_GY] = regs_ff[slot(`IDX_GY_CONTROL_AND_GAIN_UPPER)][`BIT_GY_OFFSET_EN];
      cfg_high_en[CH_GY] = regs_ff[slot(`IDX_GY_CONTROL_AND_GAIN_UPPER)][`BIT_GY_UPPER_EN];
      cfg_low_en[CH_GY] = regs_ff[slot(`IDX_GY_CONTROL_AND_GAIN_UPPER)][`BIT_GY_LOWER_EN];
      cfg_gain_en[CH_BCB] = regs_ff[slot(`IDX_CHROMA_CONTROL)][`BIT_BCB_GAIN_EN];
      cfg_gain_en[CH_RCR] = regs_ff[slot(`IDX_CHROMA_CONTROL)][`BIT_RCR_GAIN_EN];
      cfg_shift_en[CH_BCB] = regs_ff[slot(`IDX_CHROMA_CONTROL)][`BIT_BCB_OFFSET_EN];
      cfg_shift_en[CH_RCR] = regs_ff[slot(`IDX_CHROMA_CONTROL)][`BIT_RCR_OFFSET_EN];
      cfg_high_en[CH_BCB] = regs_ff[slot(`IDX_CHROMA_CONTROL)][`BIT_BCB_UPPER_EN];
      cfg_high_en[CH_RCR] = regs_ff[slot(`IDX_CHROMA_CONTROL)][`BIT_RCR_UPPER_EN];
      cfg_low_en[CH_BCB] = regs_ff[slot(`IDX_CHROMA_CONTROL)][`BIT_BCB_LOWER_EN];
      cfg_low_en[CH_RCR] = regs_ff[slot(`IDX_CHROMA_CONTROL)][`BIT_RCR_LOWER_EN];
   end

   // sample inputs gathered for the loop
   sample_t pix_in [NCH];
   assign pix_in[CH_GY] = gy_in;
   assign pix_in[CH_BCB] = bcb_in;
   assign pix_in[CH_RCR] = rcr_in;

   // pipeline valid, three stages deep for every channel
   logic [2:0] valid_ff;
   // dac outputs per channel
   sample_t dac_ff [NCH];

   // valid tracks the sample through shift, scale and clip
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         valid_ff <= 3'h0;
      end
      else
      begin
         valid_ff <= {valid_ff[1:0], pix_valid};
      end
   end

   generate
      for (genvar c = 0; c < NCH; c++)
      begin : g_chan
         // stage registers
         sample_t shifted_ff;
         sample_t scaled_ff;
         // scale arithmetic
         logic [20:0] product;
         logic [10:0] scaled_full;
         sample_t scaled_nxt;
         // clip arithmetic
         sample_t high_limit;
         sample_t clipped;

         // stage 1: downward shift
         always_ff @(posedge ref_clk)
         begin
            if (!rstn)
            begin
               shifted_ff <= 10'h000;
            end
            else if (cfg_shift_en[c])
            begin
               // modulo 1024, no floor at zero
               shifted_ff <= pix_in[c] - {2'h0, cfg_shift[c]};
            end
            else
            begin
               shifted_ff <= pix_in[c];
            end
         end

         // stage 2 arithmetic: code/1024 approximates factor (2047/1.999)
         always_comb
         begin
            product = 21'(shifted_ff) * 21'(cfg_gain[c]);
            scaled_full = product[`GAIN_FRAC_BITS +: 11];
            if (scaled_full[10] && overflow_guard_enable)
            begin
               scaled_nxt = `SAMPLE_FULL_SCALE;
            end
            else
            begin
               scaled_nxt = scaled_full[9:0];
            end
         end

         // stage 2: scale or bypass
         always_ff @(posedge ref_clk)
         begin
            if (!rstn)
            begin
               scaled_ff <= 10'h000;
            end
            else
            begin
               scaled_ff <= cfg_gain_en[c] ? scaled_nxt : shifted_ff;
            end
         end

         // stage 3 arithmetic: clip, low limit checked last
         always_comb
         begin
            high_limit = `SAMPLE_FULL_SCALE - {2'h0, cfg_high[c]};
            clipped = scaled_ff;
            if (cfg_high_en[c] && scaled_ff > high_limit)
            begin
               clipped = high_limit;
            end
            if (cfg_low_en[c] && scaled_ff < {2'h0, cfg_low[c]})
            begin
               clipped = {2'h0, cfg_low[c]};
            end
         end

         // stage 3: dac input, forced value wins when overridden
         always_ff @(posedge ref_clk)
         begin
            if (!rstn)
            begin
               dac_ff[c] <= 10'h000;
            end
            else if (dac_force)
            begin
               dac_ff[c] <= cfg_forced[c];
            end
            else
            begin
               dac_ff[c] <= clipped;
            end
         end
      end
   endgenerate

   // outputs straight from flops
   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign dac_valid = valid_ff[2];
   assign gy_dac = dac_ff[CH_GY];
   assign bcb_dac = dac_ff[CH_BCB];
   assign rcr_dac = dac_ff[CH_RCR];

endmodule : video_clip_shift_scale_dac_force

// ### inc/video_csm_defs.svh
`ifndef VIDEO_CSM_DEFS_SVH
`define VIDEO_CSM_DEFS_SVH

// register indices; byte address is four times the index
`define IDX_DAC_FORCE_AND_UPPER_BITS 8'h3D
`define IDX_GY_DAC_FORCED_LOW 8'h3E
`define IDX_BCB_DAC_FORCED_LOW 8'h3F
`define IDX_RCR_DAC_FORCED_LOW 8'h40
`define IDX_GY_LOW_CLIP_LEVEL 8'h41
`define IDX_BCB_LOW_CLIP_LEVEL 8'h42
`define IDX_RCR_LOW_CLIP_LEVEL 8'h43
`define IDX_GY_HIGH_CLIP_OFFSET 8'h44
`define IDX_BCB_HIGH_CLIP_OFFSET 8'h45
`define IDX_RCR_HIGH_CLIP_OFFSET 8'h46
`define IDX_GY_SHIFT_AMOUNT 8'h47
`define IDX_BCB_SHIFT_AMOUNT 8'h48
`define IDX_RCR_SHIFT_AMOUNT 8'h49
`define IDX_GY_CONTROL_AND_GAIN_UPPER 8'h4A
`define IDX_CHROMA_GAIN_UPPER_BITS 8'h4B
`define IDX_GY_GAIN_LOW 8'h4C
`define IDX_BCB_GAIN_LOW 8'h4D
`define IDX_RCR_GAIN_LOW 8'h4E
`define IDX_CHROMA_CONTROL 8'h4F
`define REG_COUNT 19

// reset values
`define RST_LOW_CLIP 8'h40
`define RST_GY_HIGH_CLIP 8'h53
`define RST_CHROMA_HIGH_CLIP 8'h3F
`define RST_SHIFT 8'h40
`define RST_GY_CONTROL 8'h08
`define RST_ZERO 8'h00

// writable bit masks of registers with reserved bits
`define MASK_DAC_FORCE 8'h7F
`define MASK_CHROMA_GAIN_UPPER 8'h77

// field positions, gy control register
`define BIT_GY_GAIN_EN 7
`define BIT_GY_OFFSET_EN 6
`define BIT_GY_UPPER_EN 5
`define BIT_GY_LOWER_EN 4
`define BIT_OVERFLOW_GUARD 3
// field positions, chroma control register
`define BIT_RCR_GAIN_EN 7
`define BIT_BCB_GAIN_EN 6
`define BIT_RCR_OFFSET_EN 5
`define BIT_BCB_OFFSET_EN 4
`define BIT_RCR_UPPER_EN 3
`define BIT_RCR_LOWER_EN 2
`define BIT_BCB_UPPER_EN 1
`define BIT_BCB_LOWER_EN 0
// field position, dac force
`define BIT_DAC_FORCE 6

// full scale of a 10-bit sample, top of the upper clip formula
`define SAMPLE_FULL_SCALE 10'h3FF
// gain code has 10 fraction bits (2048 codes over 0..1.999)
`define GAIN_FRAC_BITS 10

`endif

// ### inc/video_csm_pkg.sv
package video_csm_pkg;
   // one video sample
   typedef logic [9:0] sample_t;
   // one register byte
   typedef logic [7:0] reg_byte_t;
   // gain code
   typedef logic [10:0] gain_t;
   // channel numbering used by the generate loop
   typedef enum logic [1:0]
   {
      CH_GY = 2'h0,
      CH_BCB = 2'h1,
      CH_RCR = 2'h2
   } channel_t;
endpackage : video_csm_pkg

// ### verif/csm_checker_assertions.sv
module csm_checker
#(
   parameter int ADDR_W = 12
)
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // video
   input wire logic pix_valid,
   input wire logic dac_valid,
   input wire logic [9:0] gy_dac,
   input wire logic [9:0] bcb_dac,
   input wire logic [9:0] rcr_dac
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] idx; // word index
   logic bad; // refused address
   logic wr_ok; // accepted write
   logic [7:0] frc_ff, f1_ff, f2_ff, f3_ff; // shadow of force registers
   logic [1:0] up_ff; // edges since reset, stops at pipeline depth
   assign idx = paddr[9:2];
   assign bad = paddr[1:0] != 2'h0 || paddr[ADDR_W-1:10] != '0 || idx < 8'h3D || idx > 8'h4F;
   assign wr_ok = psel && penable && pready && pwrite && !bad;
   // shadow copy; reserved bit 7 is never looked at
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         frc_ff <= 8'h00;
         f1_ff <= 8'h00;
         f2_ff <= 8'h00;
         f3_ff <= 8'h00;
      end
      else if (wr_ok)
      begin
         case (idx)
            8'h3D: frc_ff <= pwdata[7:0];
            8'h3E: f1_ff <= pwdata[7:0];
            8'h3F: f2_ff <= pwdata[7:0];
            8'h40: f3_ff <= pwdata[7:0];
            default: ;
         endcase
      end
   end
   // lag counter keeps pre-reset history out of the latency check
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
         up_ff <= 2'h0;
      else if (up_ff != 2'h3)
         up_ff <= up_ff + 2'h1;
   end
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (!rstn);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_access;
      psel && penable && pready;
   endsequence
   a_answer_after_setup: assert property (s_setup |=> s_access)
      else $error("no answer one cycle after setup");
   a_ready_single: assert property (pready |=> !pready)
      else $error("ready held too long");
   a_err_decode: assert property (pready |-> pslverr == bad)
      else $error("error flag disagrees with address");
   a_err_only_ready: assert property (pslverr |-> pready)
      else $error("error flag without ready");
   a_rdata_quiet: assert property (!pready || pslverr |-> prdata == 32'h0)
      else $error("read data outside a good answer");
   a_rdata_byte: assert property (pready |-> prdata[31:8] == 24'h0)
      else $error("upper read lanes not zero");
   a_valid_lag: assert property (up_ff == 2'h3 |-> dac_valid == $past(pix_valid, 3))
      else $error("valid latency wrong");
   a_force_gy: assert property ($past(frc_ff[6]) |-> gy_dac == {$past(frc_ff[5:4]), $past(f1_ff)})
      else $error("gy dac not forced");
   a_force_bcb: assert property ($past(frc_ff[6]) |-> bcb_dac == {$past(frc_ff[3:2]), $past(f2_ff)})
      else $error("bcb dac not forced");
   a_force_rcr: assert property ($past(frc_ff[6]) |-> rcr_dac == {$past(frc_ff[1:0]), $past(f3_ff)})
      else $error("rcr dac not forced");
endmodule : csm_checker

bind video_clip_shift_scale_dac_force csm_checker #(.ADDR_W(ADDR_W)) u_chk
(
   .ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .pix_valid(pix_valid), .dac_valid(dac_valid), .gy_dac(gy_dac), .bcb_dac(bcb_dac),
   .rcr_dac(rcr_dac)
);

// ### verif/pixel_feed.sv
module pixel_feed
(
   // clock
   input wire logic ref_clk,
   // samples towards the block
   output logic pix_valid,
   output logic [9:0] gy_in,
   output logic [9:0] bcb_in,
   output logic [9:0] rcr_in
);
   timeunit 1ns;
   timeprecision 100ps;
   // idle until the first sample
   initial
   begin
      pix_valid = 1'b0;
      gy_in = 10'h000;
      bcb_in = 10'h000;
      rcr_in = 10'h000;
   end
   // one sample for one cycle; afterwards the lines flip so stale data never looks valid
   task automatic send(input logic [9:0] g, input logic [9:0] b, input logic [9:0] r);
      @(posedge ref_clk);
      pix_valid <= 1'b1;
      gy_in <= g;
      bcb_in <= b;
      rcr_in <= r;
      @(posedge ref_clk);
      pix_valid <= 1'b0;
      gy_in <= ~g;
      bcb_in <= ~b;
      rcr_in <= ~r;
   endtask : send
endmodule : pixel_feed

// ### verif/tb.sv
module tb
   import video_csm_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic ref_clk, rstn, psel, penable, pwrite, pready, pslverr, pix_valid, dac_valid;
   logic [11:0] paddr; // byte address
   logic [31:0] pwdata, prdata;
   sample_t gy_in, bcb_in, rcr_in, gy_dac, bcb_dac, rcr_dac;
   int mismatches, n_tests;
   reg_byte_t rdv; // last read byte
   logic erv; // last error flag
   // one video case: gy control byte, sample, gy and chroma results
   typedef struct packed {reg_byte_t c; sample_t s; sample_t eg; sample_t ec;} row_t;
   localparam row_t ROWS [15] = '{
      '{8'h08, 10'h123, 10'h123, 10'h123}, '{8'h48, 10'h100, 10'h0C0, 10'h0C0},
      '{8'h48, 10'h010, 10'h3D0, 10'h3D0}, '{8'h8C, 10'h155, 10'h155, 10'h155},
      '{8'h8E, 10'h200, 10'h300, 10'h300}, '{8'h8E, 10'h300, 10'h3FF, 10'h3FF},
      '{8'h86, 10'h300, 10'h080, 10'h080}, '{8'h28, 10'h3F0, 10'h3AC, 10'h3C0},
      '{8'h28, 10'h3AB, 10'h3AB, 10'h3AB}, '{8'h18, 10'h020, 10'h040, 10'h040},
      '{8'h18, 10'h041, 10'h041, 10'h041}, '{8'hC9, 10'h140, 10'h040, 10'h040},
      '{8'h0F, 10'h200, 10'h200, 10'h200}, '{8'h38, 10'h3FF, 10'h3AC, 10'h3C0},
      '{8'h38, 10'h000, 10'h040, 10'h040}};
   // reset image of indices 0x3D..0x4F
   localparam reg_byte_t RST [19] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 8'h40, 8'h40,
      8'h53, 8'h3F, 8'h3F, 8'h40, 8'h40, 8'h40, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin mismatches++; \
   $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end

   video_clip_shift_scale_dac_force #(.ADDR_W(12)) DUT
   (
      .ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pix_valid(pix_valid), .gy_in(gy_in), .bcb_in(bcb_in), .rcr_in(rcr_in),
      .dac_valid(dac_valid), .gy_dac(gy_dac), .bcb_dac(bcb_dac), .rcr_dac(rcr_dac)
   );
   pixel_feed feed
   (
      .ref_clk(ref_clk), .pix_valid(pix_valid), .gy_in(gy_in), .bcb_in(bcb_in),
      .rcr_in(rcr_in)
   );

   // 4 ns clock
   initial
   begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   // verdict, shared with the watchdog
   task automatic end_of_test();
      if (mismatches == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : end_of_test

   // apb transfer; a dead slave is caught by the watchdog, not here
   task automatic apb(input logic w, input logic [11:0] a, input reg_byte_t d);
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge ref_clk);
      penable <= 1'b1;
      do
      begin
         @(posedge ref_clk);
      end
      while (pready !== 1'b1);
      rdv = prdata[7:0];
      erv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // word index to byte address
   task automatic wr(input reg_byte_t i, input reg_byte_t d);
      apb(1'b1, {2'h0, i, 2'h0}, d);
   endtask : wr
   task automatic rd(input reg_byte_t i);
      apb(1'b0, {2'h0, i, 2'h0}, 8'h00);
   endtask : rd

   // same setting on all channels: gy byte mapped onto chroma enables and gains
   task automatic cfg(input reg_byte_t c);
      wr(8'h4A, c);
      wr(8'h4B, {1'b0, c[2:0], 1'b0, c[2:0]});
      wr(8'h4F, {c[7], c[7], c[6], c[6], c[5], c[4], c[5], c[4]});
   endtask : cfg

   // one sample through; taken at the edge send returns on, dac shows it two edges later
   task automatic run(input sample_t s, input sample_t eg, input sample_t eb, input sample_t er);
      feed.send(s, s, s);
      repeat (2) @(posedge ref_clk);
      #1;
      `CHK(gy_dac, eg)
      `CHK(bcb_dac, eb)
      `CHK(rcr_dac, er)
      `CHK(dac_valid, 1'b1)
   endtask : run

   // watchdog
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      mismatches++;
      end_of_test();
   end

   initial
   begin
      rstn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      mismatches = 0;
      n_tests = 0;
      repeat (2) @(posedge ref_clk);
      rstn <= 1'b1;
      foreach (RST[i])
      begin
         rd(8'(8'h3D + i));
         `CHK(rdv, RST[i])
      end
      foreach (ROWS[i])
      begin
         cfg(ROWS[i].c);
         run(ROWS[i].s, ROWS[i].eg, ROWS[i].ec, ROWS[i].ec);
      end
      // chroma enables set apart so a swapped bit shows
      cfg(8'h08);
      wr(8'h4F, 8'h90);
      run(10'h150, 10'h150, 10'h110, 10'h000);
      wr(8'h4F, 8'h29);
      run(10'h010, 10'h010, 10'h040, 10'h3C0);
      // low gain bytes; rcr upper bits and low byte differ to catch swaps
      cfg(8'h8C);
      wr(8'h4B, 8'h42);
      wr(8'h4C, 8'h80);
      wr(8'h4D, 8'h80);
      wr(8'h4E, 8'h40);
      run(10'h100, 10'h120, 10'h120, 10'h090);
      // forced dac values, reserved bit dropped
      wr(8'h3D, 8'hE7);
      wr(8'h3E, 8'h5A);
      wr(8'h3F, 8'hA5);
      wr(8'h40, 8'h3C);
      rd(8'h3D);
      `CHK(rdv, 8'h67)
      run(10'h111, 10'h25A, 10'h1A5, 10'h33C);
      // refused places: reserved bits, misaligned, unmapped
      wr(8'h4B, 8'hFF);
      rd(8'h4B);
      `CHK(rdv, 8'h77)
      apb(1'b1, 12'h129, 8'hFF);
      `CHK(erv, 1'b1)
      rd(8'h4A);
      `CHK(rdv, 8'h8C)
      rd(8'h3C);
      `CHK({erv, rdv}, 9'h100)
      rd(8'h50);
      `CHK(erv, 1'b1)
      @(posedge ref_clk);
      rstn <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rstn <= 1'b1;
      rd(8'h4A);
      `CHK(rdv, 8'h08)
      rd(8'h3D);
      `CHK(rdv, 8'h00)
      end_of_test();
   end
endmodule : tb
